// file: shared/frs_pkg.sv
package frs_pkg;

  // termination classes
  localparam logic [1:0] TERM_NORMAL = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL = 2'h1;
  localparam logic [1:0] TERM_INVALID = 2'h2;
  localparam logic [1:0] TERM_POLLING = 2'h3;

  // recalibrate gives up after this many steps without track zero
  localparam logic [6:0] RECAL_STEP_LIMIT = 7'h50;
  // index pulses allowed while hunting an identifier mark
  localparam logic [1:0] INDEX_PULSE_LIMIT = 2'h2;
  // identifier track number that marks a bad track
  localparam logic [7:0] BAD_TRACK_ID = 8'hFF;

  // result byte counts per answer kind
  localparam logic [2:0] BYTES_TRANSFER = 3'h7;
  localparam logic [2:0] BYTES_INTERRUPT = 3'h2;
  localparam logic [2:0] BYTES_DRIVE = 3'h1;

  // values after reset
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic DENSITY_RESET = 1'b1;

  typedef enum logic [1:0] {
    FRS_ANS_TRANSFER = 2'b00,  // status 0,1,2 then four sector id bytes
    FRS_ANS_INTERRUPT = 2'b01, // status 0 then present track
    FRS_ANS_DRIVE = 2'b10      // status 3 only
  } frs_ans_t;

  typedef enum logic [1:0] {
    FRS_IDLE = 2'b00,
    FRS_EXEC = 2'b01,
    FRS_RESULT = 2'b10
  } frs_state_t;

  // status byte zero layout
  typedef struct packed {
    logic [1:0] terminationCode;
    logic positioningDoneFlag;
    logic driveFaultFlag;
    logic unused3;
    logic head;
    logic [1:0] unitSelectField;
  } frs_st0_t;

  // status byte one layout
  typedef struct packed {
    logic endOfTrack;
    logic unused6;
    logic anyFieldCrcFlag;
    logic overrun;
    logic unused3;
    logic sectorMissingFlag;
    logic writeProtectViolationFlag;
    logic idSyncAbsentFlag;
  } frs_st1_t;

  // status byte two layout
  typedef struct packed {
    logic unused7;
    logic deletedStatusFlag;
    logic payloadCrcFlag;
    logic trackMismatchFlag;
    logic unused3;
    logic unused2;
    logic badTrackFlag;
    logic payloadSyncAbsentFlag;
  } frs_st2_t;

  // one-cycle events reported by the execution engine
  typedef struct packed {
    logic endOfTrack;
    logic idCrcError;
    logic dataCrcError;
    logic overrun;
    logic sectorMissing;
    logic deletedMismatch;
    logic dataMarkMissing;
    logic idFound;
    logic stepPulse;
  } frs_evt_t;

  // context of the terminating command, valid with cmdDone
  typedef struct packed {
    frs_ans_t answerKind;
    logic [1:0] terminationCode;
    logic seekDone;
    logic relSeekOutward;
    logic idTrackValid;
    logic [7:0] idTrack;
    logic [7:0] curTrack;
    logic [31:0] sectorId;
  } frs_cmd_t;

endpackage : frs_pkg

// file: rtl/frs_result_status_encoder.sv
`timescale 1ns/10ps

// Notes on behaviour
// - density select goes high on hardware reset, holds through both software resets
// - in result phase the data register returns status of the finished command
// - status zero bits 7:6 encode normal, abnormal, invalid or polling termination
// - status zero bit 5 flags completed seek, relative seek or recalibrate
// - equipment check when track zero missing after 80 recalibrate steps
// - equipment check also when relative seek steps outward past track zero
// - status zero bit 3 zero, bit 2 head, bits 1:0 selected drive
// - status one bit 7 flags access beyond last sector of the track
// - status one bit 5 flags crc error in identifier or data field
// - status one bit 4 flags overrun or underrun of host service
// - status one bit 2 flags sector not found or wrong sector sequence
// - status one bit 1 flags write protect seen during a write command
// - status one bit 0 flags identifier mark absent after two index pulses
// - unused status positions always read zero
// - status three bits 5 and 3 always read one
// - status two bit 6 flags data mark of the other deleted kind
// - status two bit 5 flags crc error in the data field
// - status two bit 4 flags identifier track differing from internal track
// - status two bit 1 flags mismatching identifier track equal to FF
// - status two bit 0 flags missing data or deleted data mark
// - status three shows write protect, track zero, side and drive lines as sampled at termination
module frs_result_status_encoder
  import frs_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dorReset,
  input wire logic dsrReset,
  // drive cable pins
  input wire logic writeProtectPin,
  input wire logic outerTrackSensor,
  input wire logic indexPulseInput,
  // drive selection from core
  input wire logic sideSelectOutput,
  input wire logic [1:0] unitSelectField,
  input wire logic densityRequest,
  // execution engine
  input wire logic cmdStart,
  input wire logic writeCmdActive,
  input wire logic recalActive,
  input wire logic idSearchActive,
  input wire frs_evt_t execEvent,
  input wire logic cmdDone,
  input wire frs_cmd_t cmdInfo,
  // host data register
  input wire logic hostRead,
  output logic [7:0] resultData,
  output logic hostRequestFlag,
  output logic transferDirectionFlag,
  output logic densitySelectOutput
);

  logic swReset;
  logic [2:0] pinRaw;
  logic [2:0] syncA_ff;
  logic [2:0] syncB_ff;
  logic [2:0] syncC_ff;
  logic [2:0] pinClean_ff;
  logic wpLine;
  logic trk0Line;
  logic indexLine;
  logic indexPrev_ff;
  logic indexRise;
  frs_state_t state_ff;
  frs_st1_t acc1_ff;
  frs_st2_t acc2_ff;
  logic driveFault_ff;
  logic [6:0] stepCount_ff;
  logic [1:0] indexCount_ff;
  frs_st0_t st0_ff;
  frs_st1_t st1_ff;
  frs_st2_t st2_ff;
  logic [7:0] st3Live;
  logic [7:0] st3_ff;
  logic [7:0] trackHold_ff;
  logic [31:0] idHold_ff;
  frs_ans_t ans_ff;
  logic [2:0] byteIdx_ff;
  logic [2:0] byteLast_ff;
  logic [7:0] nxt_resultData;
  logic readTaken;
  logic lastTaken;
  logic [2:0] nxt_byteIdx;
  logic trackMiss;
  logic [7:0] resultData_ff;
  logic hostRequestFlag_ff;
  logic transferDirectionFlag_ff;
  logic densitySelectOutput_ff;

  assign swReset = dorReset | dsrReset;

  // pins cross three flops; a level is taken only when stages two and three agree
  assign pinRaw = {indexPulseInput, outerTrackSensor, writeProtectPin};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_ff <= 3'h0;
      syncB_ff <= 3'h0;
      syncC_ff <= 3'h0;
    end else begin
      syncA_ff <= pinRaw;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gPin
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pinClean_ff[g] <= 1'b0;
        end else if (syncB_ff[g] == syncC_ff[g]) begin
          pinClean_ff[g] <= syncC_ff[g];
        end
      end
    end
  endgenerate

  assign wpLine = pinClean_ff[0];
  assign trk0Line = pinClean_ff[1];
  assign indexLine = pinClean_ff[2];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      indexPrev_ff <= 1'b0;
    end else begin
      indexPrev_ff <= indexLine;
    end
  end

  assign indexRise = indexLine & ~indexPrev_ff;

  // density line: only the hardware reset forces it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      densitySelectOutput_ff <= DENSITY_RESET;
    end else if (!swReset) begin
      densitySelectOutput_ff <= densityRequest;
    end
  end

  // command phase tracking
  assign readTaken = hostRead & hostRequestFlag_ff & transferDirectionFlag_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= FRS_IDLE;
    end else if (swReset) begin
      state_ff <= FRS_IDLE;
    end else begin
      case (state_ff)
        FRS_IDLE: begin
          if (cmdStart) begin
            state_ff <= FRS_EXEC;
          end
        end
        FRS_EXEC: begin
          if (cmdDone) begin
            state_ff <= FRS_RESULT;
          end
        end
        FRS_RESULT: begin
          if (readTaken && byteIdx_ff == byteLast_ff) begin
            state_ff <= FRS_IDLE;
          end
        end
        default: begin
          state_ff <= FRS_IDLE;
        end
      endcase
    end
  end

  // sticky medium faults; an event in the start cycle survives the clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc1_ff <= '0;
      acc2_ff <= '0;
    end else if (swReset) begin
      acc1_ff <= '0;
      acc2_ff <= '0;
    end else begin
      acc1_ff.endOfTrack <= (acc1_ff.endOfTrack & ~cmdStart) | execEvent.endOfTrack;
      acc1_ff.anyFieldCrcFlag <= (acc1_ff.anyFieldCrcFlag & ~cmdStart)
                                 | execEvent.idCrcError | execEvent.dataCrcError;
      acc1_ff.overrun <= (acc1_ff.overrun & ~cmdStart) | execEvent.overrun;
      acc1_ff.sectorMissingFlag <= (acc1_ff.sectorMissingFlag & ~cmdStart) | execEvent.sectorMissing;
      acc1_ff.writeProtectViolationFlag <= (acc1_ff.writeProtectViolationFlag & ~cmdStart)
                                           | (writeCmdActive & wpLine);
      acc1_ff.idSyncAbsentFlag <= (acc1_ff.idSyncAbsentFlag & ~cmdStart) | execEvent.dataMarkMissing
                                  | (idSearchActive & indexRise & indexCount_ff == INDEX_PULSE_LIMIT - 2'h1);
      acc2_ff.deletedStatusFlag <= (acc2_ff.deletedStatusFlag & ~cmdStart) | execEvent.deletedMismatch;
      acc2_ff.payloadCrcFlag <= (acc2_ff.payloadCrcFlag & ~cmdStart) | execEvent.dataCrcError;
      acc2_ff.payloadSyncAbsentFlag <= (acc2_ff.payloadSyncAbsentFlag & ~cmdStart)
                                       | execEvent.dataMarkMissing;
    end
  end

  // index pulses seen while hunting an identifier mark
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      indexCount_ff <= 2'h0;
    end else if (!idSearchActive || execEvent.idFound || cmdStart) begin
      indexCount_ff <= 2'h0;
    end else if (indexRise && indexCount_ff != INDEX_PULSE_LIMIT) begin
      indexCount_ff <= indexCount_ff + 2'h1;
    end
  end

  // recalibrate step budget; saturates so the fault is raised once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stepCount_ff <= 7'h00;
      driveFault_ff <= 1'b0;
    end else if (cmdStart || swReset) begin
      stepCount_ff <= 7'h00;
      driveFault_ff <= 1'b0;
    end else if (recalActive && execEvent.stepPulse && stepCount_ff != RECAL_STEP_LIMIT) begin
      stepCount_ff <= stepCount_ff + 7'h01;
      if (stepCount_ff == RECAL_STEP_LIMIT - 7'h01 && !trk0Line) begin
        driveFault_ff <= 1'b1;
      end
    end
  end

  assign trackMiss = cmdInfo.idTrackValid & (cmdInfo.idTrack != cmdInfo.curTrack);

  // live drive line snapshot
  assign st3Live = {1'b0, wpLine, 1'b1, trk0Line, 1'b1, sideSelectOutput, unitSelectField};

  // result bytes frozen at termination until read out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st0_ff <= '0;
      st1_ff <= '0;
      st2_ff <= '0;
      st3_ff <= RESULT_RESET;
      trackHold_ff <= RESULT_RESET;
      idHold_ff <= 32'h0000_0000;
      ans_ff <= FRS_ANS_TRANSFER;
    end else if (state_ff == FRS_EXEC && cmdDone) begin
      st0_ff.terminationCode <= cmdInfo.terminationCode;
      st0_ff.positioningDoneFlag <= cmdInfo.seekDone;
      st0_ff.driveFaultFlag <= driveFault_ff | cmdInfo.relSeekOutward;
      st0_ff.unused3 <= 1'b0;
      st0_ff.head <= sideSelectOutput;
      st0_ff.unitSelectField <= unitSelectField;
      st1_ff <= acc1_ff;
      st1_ff.unused6 <= 1'b0;
      st1_ff.unused3 <= 1'b0;
      st2_ff <= acc2_ff;
      st2_ff.trackMismatchFlag <= trackMiss;
      st2_ff.badTrackFlag <= trackMiss & (cmdInfo.idTrack == BAD_TRACK_ID);
      st3_ff <= st3Live;
      trackHold_ff <= cmdInfo.curTrack;
      idHold_ff <= cmdInfo.sectorId;
      ans_ff <= cmdInfo.answerKind;
    end
  end

  // result byte sequencing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      byteIdx_ff <= 3'h0;
      byteLast_ff <= 3'h0;
    end else if (state_ff == FRS_EXEC && cmdDone) begin
      byteIdx_ff <= 3'h0;
      case (cmdInfo.answerKind)
        FRS_ANS_INTERRUPT: byteLast_ff <= BYTES_INTERRUPT - 3'h1;
        FRS_ANS_DRIVE: byteLast_ff <= BYTES_DRIVE - 3'h1;
        default: byteLast_ff <= BYTES_TRANSFER - 3'h1;
      endcase
    end else if (readTaken) begin
      byteIdx_ff <= byteIdx_ff + 3'h1;
    end
  end

  // the edge that takes a byte already shows the next, so reads may come back to back
  assign lastTaken = readTaken & (byteIdx_ff == byteLast_ff);
  assign nxt_byteIdx = readTaken ? byteIdx_ff + 3'h1 : byteIdx_ff;

  always_comb begin
    nxt_resultData = RESULT_RESET;
    case (ans_ff)
      FRS_ANS_DRIVE: nxt_resultData = st3_ff;
      FRS_ANS_INTERRUPT: nxt_resultData = (nxt_byteIdx == 3'h0) ? st0_ff : trackHold_ff;
      default: begin
        case (nxt_byteIdx)
          3'h0: nxt_resultData = st0_ff;
          3'h1: nxt_resultData = st1_ff;
          3'h2: nxt_resultData = st2_ff;
          3'h3: nxt_resultData = idHold_ff[31:24];
          3'h4: nxt_resultData = idHold_ff[23:16];
          3'h5: nxt_resultData = idHold_ff[15:8];
          default: nxt_resultData = idHold_ff[7:0];
        endcase
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resultData_ff <= RESULT_RESET;
      hostRequestFlag_ff <= 1'b0;
      transferDirectionFlag_ff <= 1'b0;
    end else begin
      resultData_ff <= (state_ff == FRS_RESULT && !swReset && !lastTaken) ? nxt_resultData : RESULT_RESET;
      hostRequestFlag_ff <= (state_ff == FRS_RESULT) && !swReset
                            && !(readTaken && byteIdx_ff == byteLast_ff);
      transferDirectionFlag_ff <= (state_ff == FRS_RESULT) && !swReset
                                  && !(readTaken && byteIdx_ff == byteLast_ff);
    end
  end

  assign resultData = resultData_ff;
  assign hostRequestFlag = hostRequestFlag_ff;
  assign transferDirectionFlag = transferDirectionFlag_ff;
  assign densitySelectOutput = densitySelectOutput_ff;

  a_density_hold_swreset: assert property (@(posedge clk) disable iff (sys_rst)
    swReset |=> $stable(densitySelectOutput_ff))
    else $error("density line moved during software reset");

  a_density_follow: assert property (@(posedge clk) disable iff (sys_rst)
    !swReset |=> densitySelectOutput_ff == $past(densityRequest))
    else $error("density line did not follow request");

  a_term_code_capture: assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff == FRS_EXEC && cmdDone && !swReset) |=> st0_ff.terminationCode == $past(cmdInfo.terminationCode))
    else $error("termination code not captured");

  a_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
    !st0_ff.unused3 && !st1_ff.unused6 && !st1_ff.unused3 && !st2_ff.unused7 && !st2_ff.unused3 && !st2_ff.unused2)
    else $error("unused status bit not zero");

  a_st3_constant_bits: assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff == FRS_RESULT) |-> st3_ff[5] && st3_ff[3] && !st3_ff[7])
    else $error("status three fixed bits wrong");

  a_bad_track_implies: assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff == FRS_RESULT && st2_ff.badTrackFlag) |-> st2_ff.trackMismatchFlag)
    else $error("bad track without mismatch");

  a_hold_until_read: assert property (@(posedge clk) disable iff (sys_rst)
    (hostRequestFlag_ff && !readTaken && !swReset) |=> $stable(resultData_ff))
    else $error("result byte changed before it was read");

  a_wp_violation: assert property (@(posedge clk) disable iff (sys_rst || swReset)
    (writeCmdActive && wpLine && !cmdStart) |=> acc1_ff.writeProtectViolationFlag [*2])
    else $error("write protect violation not recorded");

  a_crc_both: assert property (@(posedge clk) disable iff (sys_rst || swReset)
    execEvent.dataCrcError |=> acc1_ff.anyFieldCrcFlag && acc2_ff.payloadCrcFlag)
    else $error("data crc not recorded in both bytes");

  a_flags_result_only: assert property (@(posedge clk) disable iff (sys_rst)
    hostRequestFlag_ff |-> $past(state_ff) == FRS_RESULT)
    else $error("request flag outside result phase");

endmodule : frs_result_status_encoder

// file: tb/frs_host_model.sv
`timescale 1ns/10ps

module frs_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // controller side
  input wire logic [7:0] resultData,
  input wire logic hostRequestFlag,
  input wire logic transferDirectionFlag,
  output logic hostRead,
  // test control
  input wire logic stall,
  input wire logic forceRead,
  input wire logic clearRx,
  input wire logic [3:0] gap,
  output logic [7:0] rxByte [8],
  output int rxCount
);
  logic [3:0] waitCnt;

  // requests move on the falling edge, away from the sampling edge
  always @(negedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hostRead <= 1'b0;
      waitCnt <= 4'h0;
    end else if (hostRead) begin
      hostRead <= 1'b0;
      waitCnt <= gap;
    end else if (waitCnt != 4'h0) begin
      waitCnt <= waitCnt - 4'h1;
    end else if (forceRead || (!stall && hostRequestFlag && transferDirectionFlag)) begin
      hostRead <= 1'b1;
    end
  end

  // a byte counts only if the controller offered it at the accepting edge
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxCount <= 0;
    end else if (clearRx) begin
      rxCount <= 0;
    end else if (hostRead && hostRequestFlag && transferDirectionFlag && rxCount < 8) begin
      rxByte[rxCount] <= resultData;
      rxCount <= rxCount + 1;
    end
  end
endmodule : frs_host_model

// file: tb/frs_result_status_encoder_bench.sv
`timescale 1ns/10ps

module frs_result_status_encoder_bench
  import frs_pkg::*;
;
  typedef struct {
    frs_cmd_t c;
    frs_evt_t e;
    logic s;
    logic [1:0] u;
    int n;
    logic [55:0] x;
  } frs_row_t;

  logic clk, sys_rst, dorReset, dsrReset, writeProtectPin, outerTrackSensor, indexPulseInput;
  logic sideSelectOutput, densityRequest, cmdStart, writeCmdActive, recalActive, idSearchActive;
  logic cmdDone, hostRead, hostRequestFlag, transferDirectionFlag, densitySelectOutput;
  logic stall, forceRead, clearRx;
  logic [1:0] unitSelectField;
  logic [3:0] gap;
  logic [7:0] resultData;
  logic [7:0] rxByte [8];
  frs_evt_t execEvent;
  frs_cmd_t cmdInfo, plain, recal, drv;
  frs_row_t rows [6];
  int rxCount, errors, numChecks, cycles, i, k;

  frs_result_status_encoder frs_result_status_encoder_inst (.clk(clk), .sys_rst(sys_rst),
    .dorReset(dorReset), .dsrReset(dsrReset), .writeProtectPin(writeProtectPin),
    .outerTrackSensor(outerTrackSensor), .indexPulseInput(indexPulseInput),
    .sideSelectOutput(sideSelectOutput), .unitSelectField(unitSelectField), .densityRequest(densityRequest),
    .cmdStart(cmdStart), .writeCmdActive(writeCmdActive), .recalActive(recalActive),
    .idSearchActive(idSearchActive), .execEvent(execEvent), .cmdDone(cmdDone), .cmdInfo(cmdInfo),
    .hostRead(hostRead), .resultData(resultData), .hostRequestFlag(hostRequestFlag),
    .transferDirectionFlag(transferDirectionFlag), .densitySelectOutput(densitySelectOutput));

  frs_host_model frs_host_model_inst (.clk(clk), .sys_rst(sys_rst), .resultData(resultData),
    .hostRequestFlag(hostRequestFlag), .transferDirectionFlag(transferDirectionFlag), .hostRead(hostRead),
    .stall(stall), .forceRead(forceRead), .clearRx(clearRx), .gap(gap), .rxByte(rxByte), .rxCount(rxCount));

  always #5 clk = ~clk;

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // a hang is charged as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic startCmd(input logic s, input logic [1:0] u, input logic [3:0] g);
    sideSelectOutput = s;
    unitSelectField = u;
    gap = g;
    cmdStart = 1'b1;
    clearRx = 1'b1;
    tick(1);
    cmdStart = 1'b0;
    clearRx = 1'b0;
  endtask : startCmd

  task automatic pulse(input frs_evt_t e);
    execEvent = e;
    tick(1);
    execEvent = '0;
    tick(1);
  endtask : pulse

  task automatic finishCmd(input frs_cmd_t c, input int n);
    cmdInfo = c;
    cmdDone = 1'b1;
    tick(1);
    cmdDone = 1'b0;
    // later drive changes must not leak into captured status
    sideSelectOutput = ~sideSelectOutput;
    unitSelectField = ~unitSelectField;
    for (int w = 0; w < 300 && rxCount < n; w++) tick(1);
    check(8'(rxCount), 8'(n));
  endtask : finishCmd

  task automatic runRow(input int r);
    startCmd(rows[r].s, rows[r].u, (r % 2) ? 4'h3 : 4'h0);
    pulse(rows[r].e);
    finishCmd(rows[r].c, rows[r].n);
    for (int j = 0; j < rows[r].n; j++) check(rxByte[j], rows[r].x[55-8*j -: 8]);
    tick(2);
    check({6'h00, hostRequestFlag, transferDirectionFlag}, 8'h00);
  endtask : runRow

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {dorReset, dsrReset, writeProtectPin, outerTrackSensor, indexPulseInput, sideSelectOutput} = '0;
    {densityRequest, cmdStart, writeCmdActive, recalActive, idSearchActive, cmdDone} = '0;
    {stall, forceRead, clearRx} = '0;
    unitSelectField = 2'h0;
    gap = 4'h0;
    execEvent = '0;
    plain = '{FRS_ANS_TRANSFER, TERM_NORMAL, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 32'h0000_0000};
    recal = '{FRS_ANS_INTERRUPT, TERM_ABNORMAL, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 32'h0000_0000};
    drv = '{FRS_ANS_DRIVE, TERM_NORMAL, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 32'h0000_0000};
    cmdInfo = plain;
    rows[0] = '{'{FRS_ANS_TRANSFER, TERM_NORMAL, 1'b0, 1'b0, 1'b1, 8'h05, 8'h05, 32'h0501_0302},
      9'h000, 1'b1, 2'h2, 7, 56'h06_0000_0501_0302};
    rows[1] = '{'{FRS_ANS_TRANSFER, TERM_ABNORMAL, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 32'h1200_FF03},
      9'h1A0, 1'b0, 2'h1, 7, 56'h41_B000_1200_FF03};
    rows[2] = '{'{FRS_ANS_TRANSFER, TERM_INVALID, 1'b0, 1'b0, 1'b1, 8'hFF, 8'h03, 32'h0300_0A02},
      9'h05C, 1'b0, 2'h3, 7, 56'h83_2573_0300_0A02};
    rows[3] = '{'{FRS_ANS_TRANSFER, TERM_POLLING, 1'b0, 1'b0, 1'b1, 8'h07, 8'h03, 32'h0700_0101},
      9'h000, 1'b0, 2'h0, 7, 56'hC0_0010_0700_0101};
    rows[4] = '{'{FRS_ANS_INTERRUPT, TERM_NORMAL, 1'b1, 1'b1, 1'b0, 8'h00, 8'h2A, 32'h0000_0000},
      9'h000, 1'b1, 2'h1, 2, 56'h35_2A00_0000_0000};
    rows[5] = '{drv, 9'h000, 1'b1, 2'h2, 1, 56'h2E_0000_0000_0000};
    tick(4);
    check({7'h00, densitySelectOutput}, 8'h01);
    check(resultData, 8'h00);
    sys_rst = 1'b0;
    tick(3);
    check({7'h00, densitySelectOutput}, 8'h00);
    // request moves while the soft resets are high; the line must not follow
    densityRequest = 1'b1;
    dorReset = 1'b1;
    tick(2);
    dorReset = 1'b0;
    // rate writes keep reserved bits 3 to 7 at zero, so only the reset strobe arrives here
    dsrReset = 1'b1;
    tick(1);
    check({7'h00, densitySelectOutput}, 8'h00);
    dsrReset = 1'b0;
    densityRequest = 1'b0;
    tick(2);
    check({7'h00, densitySelectOutput}, 8'h00);
    densityRequest = 1'b1;
    tick(2);
    check({7'h00, densitySelectOutput}, 8'h01);
    densityRequest = 1'b0;
    for (i = 0; i < 6; i++) runRow(i);
    // a read with nothing offered must not advance anything
    forceRead = 1'b1;
    tick(1);
    forceRead = 1'b0;
    tick(3);
    check({hostRequestFlag, transferDirectionFlag, resultData[5:0]}, 8'h00);
    runRow(0);
    startCmd(1'b0, 2'h0, 4'h0);
    writeCmdActive = 1'b1;
    tick(2);
    writeProtectPin = 1'b1;
    tick(8);
    writeCmdActive = 1'b0;
    finishCmd(plain, 7);
    writeProtectPin = 1'b0;
    check(rxByte[1], 8'h02);
    for (k = 79; k <= 80; k++) begin
      startCmd(1'b0, 2'h0, 4'h0);
      recalActive = 1'b1;
      repeat (k) pulse(9'h001);
      recalActive = 1'b0;
      finishCmd(recal, 2);
      check(rxByte[0], (k == 80) ? 8'h70 : 8'h60);
    end
    for (k = 1; k <= 2; k++) begin
      startCmd(1'b0, 2'h0, 4'h0);
      idSearchActive = 1'b1;
      repeat (k) begin
        indexPulseInput = 1'b1;
        tick(6);
        indexPulseInput = 1'b0;
        tick(6);
      end
      idSearchActive = 1'b0;
      finishCmd(plain, 7);
      check(rxByte[1], (k == 2) ? 8'h01 : 8'h00);
    end
    startCmd(1'b0, 2'h1, 4'h0);
    writeProtectPin = 1'b1;
    outerTrackSensor = 1'b1;
    tick(8);
    finishCmd(drv, 1);
    check(rxByte[0], 8'h79);
    writeProtectPin = 1'b0;
    outerTrackSensor = 1'b0;
    // software reset while the host sits on a pending answer
    stall = 1'b1;
    startCmd(1'b0, 2'h0, 4'h0);
    finishCmd(plain, 0);
    tick(3);
    check({6'h00, hostRequestFlag, transferDirectionFlag}, 8'h03);
    dsrReset = 1'b1;
    tick(1);
    dsrReset = 1'b0;
    tick(1);
    check({hostRequestFlag, transferDirectionFlag, resultData[5:0]}, 8'h00);
    stall = 1'b0;
    tick(4);
    check(8'(rxCount), 8'h00);
    sys_rst = 1'b1;
    tick(1);
    check({7'h00, densitySelectOutput}, 8'h01);
    sys_rst = 1'b0;
    tick(2);
    give_verdict();
  end
endmodule : frs_result_status_encoder_bench
